/* File: logic/adcp_host_port.sv */
// Parallel host port: result read-back, control register, write delay, conversion sequencing.
`timescale 1ns/1ps
// Overview of operation
// - Mode high enables parallel read and write.
// - Drive data only while select and read low.
// - Result bit 0 on lowest line.
// - Format bit one gives two's complement output.
// - Select with write latches control from lines.
// - Six lines fill address, convert, standby, format.
// - Write rising edge starts internal delay pulse.
// - Delay expiry with soft convert starts conversion.
// - Soft convert zero: writes never start conversion.
// - Hardware convert rising edge starts conversion.
// - End of conversion gives 80 ns low pulse.
// - Control register clears to zero on reset.
module adcp_host_port
    import adcp_pkg::*;
#(
    parameter logic [DLY_W-1:0] WR_DELAY_CYCLES = DLY_W'(WR_DELAY_DEF)
) (
    input  wire logic              REF_CLK,
    input  wire logic              NRST,
    input  wire logic              MODE,
    input  wire logic              CS_N,
    input  wire logic              RD_N,
    input  wire logic              WR_N,
    input  wire logic              HW_CONVERT_START,
    input  wire logic [DATA_W-1:0] SHARED_DATA_LINES_IN,
    output logic      [DATA_W-1:0] SHARED_DATA_LINES_OUT,
    output logic                   SHARED_DATA_LINES_OE_N,
    input  wire logic              CONV_DONE,
    input  wire logic [DATA_W-1:0] CONV_RESULT,
    output logic      [2:0]        CHANNEL,
    output logic                   STANDBY,
    output logic                   HOLD,
    output logic                   CONV_START,
    output logic                   EOC_N
);

    // ------------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------------
    adcp_pins_if pins ();

    adcp_pin_sync u_sync (
        .REF_CLK (REF_CLK),
        .NRST    (NRST),
        .RAW_IN  ({MODE, HW_CONVERT_START, WR_N, RD_N, CS_N, SHARED_DATA_LINES_IN}),
        .pins    (pins.src)
    );

    logic wr_n_q;
    logic conv_q;
    logic next_wr_n_q;
    logic next_conv_q;
    logic wr_rise;
    logic hw_rise;
    logic rd_sel;
    logic wr_sel;

    assign rd_sel  = pins.mode && !pins.cs_n && !pins.rd_n;
    assign wr_sel  = pins.mode && !pins.cs_n && !pins.wr_n;
    assign wr_rise = pins.wr_n && !wr_n_q;
    assign hw_rise = pins.conv && !conv_q;

    always_comb begin
        next_wr_n_q = pins.wr_n;
        next_conv_q = pins.conv;
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            wr_n_q <= 1'b1;
            conv_q <= 1'b0;
        end else begin
            wr_n_q <= next_wr_n_q;
            conv_q <= next_conv_q;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] next_ctrl;
    logic              soft_convert_bit;
    logic              soft_standby_bit;
    logic              format_bit;

    assign soft_convert_bit = ctrl[CTRL_SOFTCONV];
    assign soft_standby_bit = ctrl[CTRL_STANDBY];
    assign format_bit       = ctrl[CTRL_FORMAT];

    // The value held at the end of the strobe is the one that stays.
    always_comb begin
        next_ctrl = ctrl;
        if (wr_sel) begin
            next_ctrl = pins.data[CTRL_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl <= CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    assign CHANNEL = ctrl[CTRL_ADDR_MSB:CTRL_ADDR_LSB];
    assign STANDBY = soft_standby_bit;

    // ------------------------------------------------------------------
    // Write-triggered delay
    // ------------------------------------------------------------------
    logic [DLY_W-1:0] dly_cnt;
    logic [DLY_W-1:0] next_dly_cnt;
    logic             dly_expire;

    assign dly_expire = (dly_cnt == DLY_ONE) && !(wr_rise && pins.mode);

    always_comb begin
        next_dly_cnt = dly_cnt;
        if (wr_rise && pins.mode) begin
            next_dly_cnt = WR_DELAY_CYCLES;
        end else if (dly_cnt != DLY_ZERO) begin
            next_dly_cnt = dly_cnt - DLY_ONE;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            dly_cnt <= DLY_ZERO;
        end else begin
            dly_cnt <= next_dly_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------
    adcp_seq_t         state;
    adcp_seq_t         next_state;
    logic [EOC_W-1:0]  eoc_cnt;
    logic [EOC_W-1:0]  next_eoc_cnt;
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] next_result;
    logic              next_hold;
    logic              next_conv_start;
    logic              next_eoc_n;
    logic              start_req;

    // Start requests while a conversion runs are ignored.
    assign start_req = hw_rise || (dly_expire && soft_convert_bit);

    always_comb begin
        next_state      = state;
        next_eoc_cnt    = eoc_cnt;
        next_result     = result;
        next_hold       = HOLD;
        next_conv_start = 1'b0;
        next_eoc_n      = EOC_N;
        case (state)
            SEQ_IDLE: begin
                if (start_req) begin
                    next_state      = SEQ_CONV;
                    next_hold       = 1'b1;
                    next_conv_start = 1'b1;
                end
            end
            SEQ_CONV: begin
                if (CONV_DONE) begin
                    next_state   = SEQ_EOC;
                    next_result  = CONV_RESULT;
                    next_hold    = 1'b0;
                    next_eoc_n   = 1'b0;
                    next_eoc_cnt = EOC_LOAD;
                end
            end
            SEQ_EOC: begin
                if (eoc_cnt == EOC_ZERO) begin
                    next_state = SEQ_IDLE;
                    next_eoc_n = 1'b1;
                end else begin
                    next_eoc_cnt = eoc_cnt - EOC_ONE;
                end
            end
            default: begin
                next_state = SEQ_IDLE;
                next_hold  = 1'b0;
                next_eoc_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            state      <= SEQ_IDLE;
            eoc_cnt    <= EOC_ZERO;
            result     <= RESULT_RESET;
            HOLD       <= 1'b0;
            CONV_START <= 1'b0;
            EOC_N      <= 1'b1;
        end else begin
            state      <= next_state;
            eoc_cnt    <= next_eoc_cnt;
            result     <= next_result;
            HOLD       <= next_hold;
            CONV_START <= next_conv_start;
            EOC_N      <= next_eoc_n;
        end
    end

    // ------------------------------------------------------------------
    // Read-back drive
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] fmt_result;
    logic [DATA_W-1:0] next_data_out;
    logic              next_oe_n;

    // Two's complement of an offset-binary code is the code with its top bit flipped.
    assign fmt_result = format_bit ? {~result[DATA_W-1], result[DATA_W-2:0]} : result;

    always_comb begin
        next_data_out = fmt_result;
        next_oe_n     = !rd_sel;
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            SHARED_DATA_LINES_OUT  <= RESULT_RESET;
            SHARED_DATA_LINES_OE_N <= 1'b1;
        end else begin
            SHARED_DATA_LINES_OUT  <= next_data_out;
            SHARED_DATA_LINES_OE_N <= next_oe_n;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    sequence s_eoc_pulse;
        !EOC_N [*4] ##1 EOC_N;
    endsequence

    sequence s_conv_begin;
        CONV_START && HOLD ##1 !CONV_START && HOLD;
    endsequence

    property p_mode_gate;
        !pins.mode |=> SHARED_DATA_LINES_OE_N;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("Lines driven outside mode.");

    property p_drive;
        rd_sel |=> !SHARED_DATA_LINES_OE_N ##1 ($past(rd_sel) != SHARED_DATA_LINES_OE_N);
    endproperty
    a_drive: assert property (p_drive) else $error("Drive does not follow strobes.");

    property p_read_data;
        rd_sel && !format_bit |=> SHARED_DATA_LINES_OUT == $past(result);
    endproperty
    a_read_data: assert property (p_read_data) else $error("Read data bit order wrong.");

    property p_read_twos;
        rd_sel && format_bit |=> SHARED_DATA_LINES_OUT[DATA_W-1] != $past(result[DATA_W-1]);
    endproperty
    a_read_twos: assert property (p_read_twos) else $error("Output coding wrong.");

    property p_write;
        wr_sel |=> ctrl == $past(pins.data[CTRL_W-1:0])
            && CHANNEL == $past(pins.data[CTRL_ADDR_MSB:CTRL_ADDR_LSB]);
    endproperty
    a_write: assert property (p_write) else $error("Control not latched.");

    property p_delay;
        wr_rise && pins.mode |=> dly_cnt == WR_DELAY_CYCLES;
    endproperty
    a_delay: assert property (p_delay) else $error("Write delay not started.");

    property p_soft_start;
        state == SEQ_IDLE && dly_expire && soft_convert_bit |=> s_conv_begin;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("Soft start missed.");

    property p_soft_off;
        state == SEQ_IDLE && !hw_rise && !soft_convert_bit |=> !CONV_START;
    endproperty
    a_soft_off: assert property (p_soft_off) else $error("Write started conversion.");

    property p_hw_start;
        state == SEQ_IDLE && hw_rise |=> s_conv_begin;
    endproperty
    a_hw_start: assert property (p_hw_start) else $error("Hardware start missed.");

    property p_eoc;
        state == SEQ_CONV && CONV_DONE |=> s_eoc_pulse;
    endproperty
    a_eoc: assert property (p_eoc) else $error("End pulse length wrong.");

endmodule : adcp_host_port

/* File: shared/adcp_pkg.sv */
// Constants, timing figures and state types of the parallel host port.
package adcp_pkg;

    // ------------------------------------------------------------------
    // Widths and timing
    // ------------------------------------------------------------------
    localparam int DATA_W        = 12;
    localparam int SYNC_W        = 17;
    localparam int DLY_W         = 8;
    localparam int EOC_W         = 3;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WR_DELAY_NS   = 400;
    localparam int EOC_PULSE_NS  = 80;
    localparam int WR_DELAY_DEF  = (WR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EOC_CYCLES    = (EOC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [DLY_W-1:0] DLY_ZERO  = 8'h00;
    localparam logic [DLY_W-1:0] DLY_ONE   = 8'h01;
    localparam logic [EOC_W-1:0] EOC_ZERO  = 3'h0;
    localparam logic [EOC_W-1:0] EOC_ONE   = 3'h1;
    localparam logic [EOC_W-1:0] EOC_LOAD  = EOC_W'(EOC_CYCLES - 1);

    // ------------------------------------------------------------------
    // Control register layout and reset value
    // ------------------------------------------------------------------
    localparam int CTRL_W         = 6;
    localparam int CTRL_FORMAT    = 0;
    localparam int CTRL_STANDBY   = 1;
    localparam int CTRL_SOFTCONV  = 2;
    localparam int CTRL_ADDR_LSB  = 3;
    localparam int CTRL_ADDR_MSB  = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // ------------------------------------------------------------------
    // Synchroniser vector layout and idle levels
    // ------------------------------------------------------------------
    localparam int SYNC_DATA_MSB = 11;
    localparam int SYNC_CS       = 12;
    localparam int SYNC_RD       = 13;
    localparam int SYNC_WR       = 14;
    localparam int SYNC_CONV     = 15;
    localparam int SYNC_MODE     = 16;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 17'h07000;

    localparam logic [DATA_W-1:0] RESULT_RESET = 12'h000;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONV,
        SEQ_EOC
    } adcp_seq_t;

endpackage : adcp_pkg

/* File: shared/adcp_pins_if.sv */
// Filtered host pin levels passed from the synchroniser to the port logic.
`timescale 1ns/1ps
interface adcp_pins_if;
    import adcp_pkg::*;
    logic              mode;
    logic              conv;
    logic              wr_n;
    logic              rd_n;
    logic              cs_n;
    logic [DATA_W-1:0] data;
    modport src (output mode, conv, wr_n, rd_n, cs_n, data);
    modport dst (input mode, conv, wr_n, rd_n, cs_n, data);
endinterface : adcp_pins_if

/* File: logic/adcp_pin_sync.sv */
// Three-stage synchroniser with agreement filter for the host pins.
`timescale 1ns/1ps
module adcp_pin_sync
    import adcp_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              NRST,
    input  wire logic [SYNC_W-1:0] RAW_IN,
    adcp_pins_if.src               pins
);

    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
    logic [SYNC_W-1:0] next_filt;

    // A level is taken only once the second and third stages agree.
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_bit
            always_comb begin
                next_filt[g] = (s2[g] == s3[g]) ? s3[g] : filt[g];
            end
        end
    endgenerate

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            s1   <= SYNC_RESET;
            s2   <= SYNC_RESET;
            s3   <= SYNC_RESET;
            filt <= SYNC_RESET;
        end else begin
            s1   <= RAW_IN;
            s2   <= s1;
            s3   <= s2;
            filt <= next_filt;
        end
    end

    assign pins.data = filt[SYNC_DATA_MSB:0];
    assign pins.cs_n = filt[SYNC_CS];
    assign pins.rd_n = filt[SYNC_RD];
    assign pins.wr_n = filt[SYNC_WR];
    assign pins.conv = filt[SYNC_CONV];
    assign pins.mode = filt[SYNC_MODE];

endmodule : adcp_pin_sync

/* File: sim/adcp_host_model.sv */
// Host processor bus model that drives the parallel port strobes and data lines.
`timescale 1ns/1ps
module adcp_host_model
    import adcp_pkg::*;
(
    input  wire logic              REF_CLK,
    input  wire logic              DEV_OE_N,
    output logic                   MODE,
    output logic                   CS_N,
    output logic                   RD_N,
    output logic                   WR_N,
    output logic      [DATA_W-1:0] DATA
);
    initial begin
        MODE = 1'b1;
        CS_N = 1'b1;
        RD_N = 1'b1;
        WR_N = 1'b1;
        DATA = 12'h5a5;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask : tick

    // Released lines carry the inverse of the last value so a stale level never matches.
    task automatic do_write(input logic m, input logic [5:0] ctrl);
        tick(1);
        MODE = m;
        CS_N = 1'b0;
        WR_N = 1'b0;
        DATA = {6'h00, ctrl};
        tick(8);
        WR_N = 1'b1;
        tick(2);
        CS_N = 1'b1;
        DATA = ~DATA;
        tick(6);
        MODE = 1'b1;
    endtask : do_write

    task automatic do_read(input logic m);
        tick(1);
        MODE = m;
        CS_N = 1'b0;
        RD_N = 1'b0;
        for (int i = 0; i < 20; i++) begin
            if (DEV_OE_N === 1'b0) break;
            tick(1);
        end
        tick(2);
        CS_N = 1'b1;
        RD_N = 1'b1;
        MODE = 1'b1;
    endtask : do_read
endmodule : adcp_host_model

/* File: sim/adcp_host_port_tb.sv */
// Self-checking testbench of the parallel host port.
`timescale 1ns/1ps
module adcp_host_port_tb;
    import adcp_pkg::*;
    logic              ref_clk = 1'b0;
    logic              nrst = 1'b0;
    logic              hw_conv = 1'b0;
    logic              conv_done = 1'b0;
    logic [DATA_W-1:0] conv_result = 12'h000;
    logic              mode, cs_n, rd_n, wr_n;
    logic [DATA_W-1:0] host_data, data_in, data_out, last_res;
    logic              oe_n, standby, hold, conv_start, eoc_n, oe_q;
    logic [2:0]        channel;
    logic [DATA_W-1:0] exp_q[$];
    int                n_errors = 0;
    int                check_count = 0;
    int                n_conv = 0;
    int                busy = 0;
    int                eoc_len = 0;
    int                n0;
    logic              st;

    always #10 ref_clk = ~ref_clk;

    assign data_in = (oe_n === 1'b0) ? data_out : host_data;

    adcp_host_model host_u (.REF_CLK(ref_clk), .DEV_OE_N(oe_n), .MODE(mode), .CS_N(cs_n),
        .RD_N(rd_n), .WR_N(wr_n), .DATA(host_data));

    adcp_host_port #(.WR_DELAY_CYCLES(8'h02)) dut_u (
        .REF_CLK(ref_clk), .NRST(nrst), .MODE(mode), .CS_N(cs_n), .RD_N(rd_n),
        .WR_N(wr_n), .HW_CONVERT_START(hw_conv), .SHARED_DATA_LINES_IN(data_in),
        .SHARED_DATA_LINES_OUT(data_out), .SHARED_DATA_LINES_OE_N(oe_n),
        .CONV_DONE(conv_done), .CONV_RESULT(conv_result), .CHANNEL(channel),
        .STANDBY(standby), .HOLD(hold), .CONV_START(conv_start), .EOC_N(eoc_n));

    // ------------------------------------------------------------------
    // Converter core model
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        conv_done <= 1'b0;
        conv_result <= ~conv_result;
        if (conv_start === 1'b1) begin
            n_conv++;
            busy = $urandom_range(9, 3);
        end else if (busy == 1) begin
            busy = 0;
            last_res = 12'($urandom);
            conv_done <= 1'b1;
            conv_result <= last_res;
        end else if (busy > 1) begin
            busy--;
        end
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // ------------------------------------------------------------------
    // Output watcher
    // ------------------------------------------------------------------
    always @(negedge ref_clk) begin
        if (oe_n === 1'b0 && oe_q !== 1'b0) begin
            if (exp_q.size() == 0) check(12'h001, 12'h000);
            else check(data_out, exp_q.pop_front());
        end
        oe_q = oe_n;
        if (conv_done === 1'b1) check({11'h000, hold}, 12'h001);
        if (eoc_n === 1'b0) eoc_len++;
        else if (eoc_len != 0) begin
            check(12'(eoc_len), 12'(EOC_CYCLES));
            eoc_len = 0;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic hw_pulse();
        hw_conv = 1'b1;
        tick(8);
        hw_conv = 1'b0;
        tick(30);
    endtask : hw_pulse

    task automatic read_expect(input logic fmt);
        exp_q.push_back(last_res ^ {fmt, 11'h000});
        host_u.do_read(1'b1);
        tick(10);
        check({11'h000, oe_n}, 12'h001);
    endtask : read_expect

    task automatic conclude();
        $display("checks=%0d n_errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    initial begin
        #400_000;
        n_errors++;
        conclude();
    end

    initial begin
        void'($urandom(32'hf977));
        tick(20);
        nrst = 1'b1;
        check({4'h0, oe_n, eoc_n, standby, hold, conv_start, channel}, 12'h0c0);
        for (int ch = 0; ch < 8; ch++) begin
            st = 1'($urandom);
            host_u.do_write(1'b1, {3'(ch), 1'b0, st, 1'b0});
            tick(4);
            check({8'h00, channel, standby}, {8'h00, 3'(ch), st});
        end
        n0 = n_conv;
        host_u.do_write(1'b0, 6'h2c);
        tick(30);
        check({9'h000, channel}, 12'h007);
        check(12'(n_conv - n0), 12'h000);
        host_u.do_read(1'b0);
        tick(10);
        check({11'h000, oe_n}, 12'h001);
        for (int f = 0; f < 2; f++) begin
            n0 = n_conv;
            hw_pulse();
            check(12'(n_conv - n0), 12'h001);
            host_u.do_write(1'b1, {3'h2, 2'b00, 1'(f)});
            tick(30);
            check(12'(n_conv - n0), 12'h001);
            read_expect(1'(f));
        end
        n0 = n_conv;
        host_u.do_write(1'b1, 6'h25);
        tick(30);
        check(12'(n_conv - n0), 12'h001);
        check({9'h000, channel}, 12'h004);
        read_expect(1'b1);
        check(12'(exp_q.size()), 12'h000);
        conclude();
    end
endmodule : adcp_host_port_tb
